// [mtf_board.sv]
// Board model: pull resistors and outside parts on the six terminals
`timescale 1ns/1ns
module mtf_board (
    input wire logic [5:0] pad_out,
    input wire logic [5:0] pad_oe,
    input wire logic [5:0] pull_up,
    input wire logic [5:0] ext_oe,
    input wire logic [5:0] ext_lvl,
    output logic [5:0] pad_in
);
    // Chip drive wins, then an outside part, else the resistor level
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_oe[i]) begin
                pad_in[i] = ext_lvl[i];
            end else begin
                pad_in[i] = pull_up[i];
            end
        end
    end
endmodule // mtf_board

// [mtf_pin_mux.sv]
// Chooses between general-purpose and alternate function for one terminal
`timescale 1ns/1ns
module mtf_pin_mux (
    input wire logic alt_sel,
    input wire logic alt_out,
    input wire logic alt_oe,
    input wire logic gpio_dir,
    input wire logic gpio_out,
    output logic pad_out,
    output logic pad_oe
);
    assign pad_out = alt_sel ? alt_out : gpio_out;
    assign pad_oe = alt_sel ? alt_oe : gpio_dir;
endmodule // mtf_pin_mux

// [mtf_pkg.sv]
// Constants and types shared by the miscellaneous terminal function select block
package mtf_pkg;

    // Register offsets, byte addresses on the register port
    localparam logic [7:0] MTF_OFS_GPIO_CTRL = 8'h00;
    localparam logic [7:0] MTF_OFS_GPIO_DATA = 8'h04;
    localparam logic [7:0] MTF_OFS_GEN_CTRL = 8'h08;
    localparam logic [7:0] MTF_OFS_STATUS = 8'h0C;

    // Reset values
    localparam logic [5:0] MTF_GPIO_DIR_RST = 6'h00;
    localparam logic [5:0] MTF_GPIO_DATA_RST = 6'h00;
    localparam logic [2:0] MTF_POWER_OVERRIDE_OUTPUT_RST = 3'h0;

    // Power override select field position and the codes that claim terminal one
    localparam int MTF_POWER_OVERRIDE_OUTPUT_LSB = 20;
    localparam int MTF_POWER_OVERRIDE_OUTPUT_MSB = 22;
    localparam logic [2:0] MTF_POWER_OVERRIDE_OUTPUT_CODE_A = 3'h1;
    localparam logic [2:0] MTF_POWER_OVERRIDE_OUTPUT_CODE_B = 3'h3;

    // Status register bit positions
    localparam int MTF_STS_CLK_RUN = 0;
    localparam int MTF_STS_EXT_ARB = 1;
    localparam int MTF_STS_COMPAT = 2;
    localparam int MTF_STS_SBUS = 3;
    localparam int MTF_STS_CLK_REQ = 4;
    localparam int MTF_STS_DONE = 5;

    // Number of terminals and of straps
    localparam int MTF_NUM_PINS = 6;
    localparam int MTF_NUM_STRAPS = 2;

    // Cycles to wait after reset release so the synchronisers hold real pin levels
    localparam logic [1:0] MTF_FILL_CYCLES = 2'h2;

    // Power-on sampling sequence
    typedef enum logic [2:0] {
        MTF_FILL = 3'b001,
        MTF_SAMPLE = 3'b010,
        MTF_RUN = 3'b100
    } mtf_state_t;

endpackage

// [mtf_sync.sv]
// Two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
module mtf_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // mtf_sync

// [mtf_terminal_select.sv]
// Miscellaneous terminal function select and strap capture
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module mtf_terminal_select (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic clock_stop_support_strap,
    input wire logic outside_arbiter_strap,
    input wire logic general_io_zero_in,
    output logic general_io_zero_out,
    output logic general_io_zero_oe,
    input wire logic general_io_one_in,
    output logic general_io_one_out,
    output logic general_io_one_oe,
    input wire logic general_io_two_in,
    output logic general_io_two_out,
    output logic general_io_two_oe,
    input wire logic general_io_three_in,
    output logic general_io_three_out,
    output logic general_io_three_oe,
    input wire logic general_io_four_in,
    output logic general_io_four_out,
    output logic general_io_four_oe,
    input wire logic general_io_five_in,
    output logic general_io_five_out,
    output logic general_io_five_oe,
    input wire logic power_override_level,
    input wire logic sbus_scl_drive_low,
    input wire logic sbus_sda_drive_low,
    output logic sbus_scl_in,
    output logic sbus_sda_in,
    output logic clock_run_support,
    output logic outside_arbiter_select,
    output logic clock_stop_request_in,
    output logic compat_mode,
    output logic sbus_mode,
    output logic detect_done
);
    import mtf_pkg::*;

    localparam int SYNC_W = MTF_NUM_PINS + MTF_NUM_STRAPS;

    logic [MTF_NUM_PINS-1:0] pin_in;
    logic [MTF_NUM_PINS-1:0] pin_out;
    logic [MTF_NUM_PINS-1:0] pin_oe;
    logic [MTF_NUM_PINS-1:0] pin_sync;
    logic [MTF_NUM_STRAPS-1:0] strap_sync;
    logic [MTF_NUM_PINS-1:0] alt_sel;
    logic [MTF_NUM_PINS-1:0] alt_out;
    logic [MTF_NUM_PINS-1:0] alt_oe;
    logic [5:0] gpio_dir_reg;
    logic [5:0] gpio_data_reg;
    logic [2:0] power_override_output_reg;
    logic clk_run_reg;
    logic ext_arb_reg;
    logic clk_req_reg;
    logic compat_reg;
    logic sbus_reg;
    logic done_reg;
    logic [1:0] fill_cnt_reg;
    mtf_state_t state_reg;
    logic ovrd_active;
    logic [31:0] read_next;
    logic [31:0] rdata_reg;

    assign pin_in = {general_io_five_in, general_io_four_in, general_io_three_in,
                     general_io_two_in, general_io_one_in, general_io_zero_in};

    // Straps and terminals pass two flip-flops before any logic reads them
    mtf_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .async_in({outside_arbiter_strap, clock_stop_support_strap, pin_in}),
        .sync_out({strap_sync, pin_sync})
    );

    // Strap levels
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_run_reg <= 1'b0;
            ext_arb_reg <= 1'b0;
        end else begin
            clk_run_reg <= strap_sync[0];
            ext_arb_reg <= strap_sync[1];
        end
    end

    // Clock-run request level taken from terminal zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_req_reg <= 1'b1;
        end else begin
            clk_req_reg <= clk_run_reg ? pin_sync[0] : 1'b1;
        end
    end

    // Sampling sequence after reset release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= MTF_FILL;
            fill_cnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                MTF_FILL: begin
                    fill_cnt_reg <= fill_cnt_reg + 2'h1;
                    if (fill_cnt_reg == MTF_FILL_CYCLES - 2'h1) begin
                        state_reg <= MTF_SAMPLE;
                    end
                end
                MTF_SAMPLE: begin
                    state_reg <= MTF_RUN;
                end
                MTF_RUN: begin
                    state_reg <= MTF_RUN;
                end
                default: begin
                    state_reg <= MTF_FILL;
                    fill_cnt_reg <= 2'h0;
                end
            endcase
        end
    end

    // Captured modes, held until the next reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            compat_reg <= 1'b0;
            sbus_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (state_reg == MTF_SAMPLE) begin
            compat_reg <= pin_sync[2];
            sbus_reg <= pin_sync[5];
            done_reg <= 1'b1;
        end
    end

    // Register writes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_dir_reg <= MTF_GPIO_DIR_RST;
            gpio_data_reg <= MTF_GPIO_DATA_RST;
            power_override_output_reg <= MTF_POWER_OVERRIDE_OUTPUT_RST;
        end else if (reg_wr) begin
            if (reg_addr == MTF_OFS_GPIO_CTRL) begin
                gpio_dir_reg <= reg_wdata[5:0];
            end
            if (reg_addr == MTF_OFS_GPIO_DATA) begin
                gpio_data_reg <= reg_wdata[5:0];
            end
            if (reg_addr == MTF_OFS_GEN_CTRL) begin
                power_override_output_reg <= reg_wdata[MTF_POWER_OVERRIDE_OUTPUT_MSB:MTF_POWER_OVERRIDE_OUTPUT_LSB];
            end
        end
    end

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        read_next = 32'h0000_0000;
        case (reg_addr)
            MTF_OFS_GPIO_CTRL: begin
                read_next[5:0] = gpio_dir_reg;
            end
            MTF_OFS_GPIO_DATA: begin
                read_next[5:0] = pin_sync;
            end
            MTF_OFS_GEN_CTRL: begin
                read_next[MTF_POWER_OVERRIDE_OUTPUT_MSB:MTF_POWER_OVERRIDE_OUTPUT_LSB] = power_override_output_reg;
            end
            MTF_OFS_STATUS: begin
                read_next[MTF_STS_CLK_RUN] = clk_run_reg;
                read_next[MTF_STS_EXT_ARB] = ext_arb_reg;
                read_next[MTF_STS_COMPAT] = compat_reg;
                read_next[MTF_STS_SBUS] = sbus_reg;
                read_next[MTF_STS_CLK_REQ] = clk_req_reg;
                read_next[MTF_STS_DONE] = done_reg;
            end
            default: begin
                read_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? read_next : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

    // Alternate function selection per terminal
    assign ovrd_active = (power_override_output_reg == MTF_POWER_OVERRIDE_OUTPUT_CODE_A) ||
                         (power_override_output_reg == MTF_POWER_OVERRIDE_OUTPUT_CODE_B);

    always_comb begin
        alt_sel = '0;
        alt_out = '0;
        alt_oe = '0;
        alt_sel[0] = clk_run_reg;
        alt_sel[1] = ovrd_active;
        alt_out[1] = power_override_level;
        alt_oe[1] = 1'b1;
        // Serial terminals float until the pull has been sampled
        alt_sel[4] = sbus_reg || !done_reg;
        alt_oe[4] = sbus_reg && sbus_scl_drive_low;
        alt_sel[5] = sbus_reg || !done_reg;
        alt_oe[5] = sbus_reg && sbus_sda_drive_low;
    end

    // Direction bits steer terminals in their general-purpose role
    genvar gi;
    generate
        for (gi = 0; gi < MTF_NUM_PINS; gi++) begin : g_pin
            mtf_pin_mux u_mux (
                .alt_sel(alt_sel[gi]),
                .alt_out(alt_out[gi]),
                .alt_oe(alt_oe[gi]),
                .gpio_dir(gpio_dir_reg[gi]),
                .gpio_out(gpio_data_reg[gi]),
                .pad_out(pin_out[gi]),
                .pad_oe(pin_oe[gi])
            );
        end
    endgenerate

    assign general_io_zero_out = pin_out[0];
    assign general_io_zero_oe = pin_oe[0];
    assign general_io_one_out = pin_out[1];
    assign general_io_one_oe = pin_oe[1];
    assign general_io_two_out = pin_out[2];
    assign general_io_two_oe = pin_oe[2];
    assign general_io_three_out = pin_out[3];
    assign general_io_three_oe = pin_oe[3];
    assign general_io_four_out = pin_out[4];
    assign general_io_four_oe = pin_oe[4];
    assign general_io_five_out = pin_out[5];
    assign general_io_five_oe = pin_oe[5];

    assign sbus_scl_in = sbus_reg ? pin_sync[4] : 1'b1;
    assign sbus_sda_in = sbus_reg ? pin_sync[5] : 1'b1;
    assign clock_run_support = clk_run_reg;
    assign outside_arbiter_select = ext_arb_reg;
    assign clock_stop_request_in = clk_req_reg;
    assign compat_mode = compat_reg;
    assign sbus_mode = sbus_reg;
    assign detect_done = done_reg;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence sample_seq;
        state_reg == MTF_SAMPLE;
    endsequence

    sequence settle_seq;
        state_reg == MTF_RUN ##1 state_reg == MTF_RUN;
    endsequence

    clock_run_strap_a: assert property (
        ##1 clk_run_reg == $past(strap_sync[0]) && clock_run_support == clk_run_reg)
        else $error("Clock-run support does not follow its strap");

    arbiter_strap_a: assert property (
        ##1 outside_arbiter_select == $past(strap_sync[1]))
        else $error("Arbiter select does not follow its strap");

    pin_zero_dir_a: assert property (
        !clk_run_reg |-> general_io_zero_oe == gpio_dir_reg[0] &&
        general_io_zero_out == gpio_data_reg[0])
        else $error("Terminal zero ignores its direction bit");

    clock_run_input_a: assert property (
        clk_run_reg |-> !general_io_zero_oe ##1
        (clk_run_reg -> clock_stop_request_in == $past(pin_sync[0])))
        else $error("Terminal zero not a clock-run input");

    pin_one_dir_a: assert property (
        !ovrd_active |-> general_io_one_oe == gpio_dir_reg[1])
        else $error("Terminal one ignores its direction bit");

    power_override_a: assert property (
        (power_override_output_reg == 3'h1 || power_override_output_reg == 3'h3) |->
        general_io_one_oe && general_io_one_out == power_override_level)
        else $error("Terminal one not driving the override output");

    pin_two_dir_a: assert property (
        general_io_two_oe == gpio_dir_reg[2] && general_io_two_out == gpio_data_reg[2])
        else $error("Terminal two ignores its direction bit");

    compat_sample_a: assert property (
        sample_seq |=> compat_mode == $past(pin_sync[2]) ##1 $stable(compat_mode))
        else $error("Compatibility mode not taken from terminal two");

    pin_three_dir_a: assert property (
        general_io_three_oe == gpio_dir_reg[3])
        else $error("Terminal three ignores its direction bit");

    serial_clock_sel_a: assert property (
        done_reg && !sbus_reg |-> general_io_four_oe == gpio_dir_reg[4] &&
        sbus_scl_in)
        else $error("Terminal four role wrong for the sampled pull");

    serial_data_sel_a: assert property (
        done_reg && sbus_reg |-> general_io_five_oe == sbus_sda_drive_low &&
        !general_io_five_out)
        else $error("Data terminal role wrong for the sampled pull");

    pull_latch_a: assert property (
        settle_seq |-> $stable(sbus_mode) && detect_done)
        else $error("Serial-bus selection changed after sampling");

    sample_timing_a: assert property (
        $rose(detect_done) |-> $past(state_reg) == MTF_SAMPLE &&
        sbus_mode == $past(pin_sync[5]))
        else $error("Pull sampled at the wrong moment");

endmodule // mtf_terminal_select

// [test_mtf_terminal_select.sv]
// Self-checking testbench for the terminal function select block
`timescale 1ns/1ns
module test_mtf_terminal_select;
    import mtf_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic clk_strap = 1'b0;
    logic arb_strap = 1'b0;
    logic pwr_lvl = 1'b0;
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    logic [5:0] pull_up = 6'h00;
    logic [5:0] ext_oe = 6'h00;
    logic [5:0] ext_lvl = 6'h00;
    wire logic [5:0] pad_in;
    wire logic [5:0] pad_out;
    wire logic [5:0] pad_oe;
    logic scl_in, sda_in, crun, oarb, creq, compat, sbus, done;
    logic [31:0] rv;
    int n_errors = 0;
    int compares = 0;

    always #50 ref_clk = ~ref_clk;

    mtf_board board_u (
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .pull_up(pull_up),
        .ext_oe(ext_oe),
        .ext_lvl(ext_lvl),
        .pad_in(pad_in)
    );

    mtf_terminal_select dut_u (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .clock_stop_support_strap(clk_strap),
        .outside_arbiter_strap(arb_strap),
        .general_io_zero_in(pad_in[0]),
        .general_io_zero_out(pad_out[0]),
        .general_io_zero_oe(pad_oe[0]),
        .general_io_one_in(pad_in[1]),
        .general_io_one_out(pad_out[1]),
        .general_io_one_oe(pad_oe[1]),
        .general_io_two_in(pad_in[2]),
        .general_io_two_out(pad_out[2]),
        .general_io_two_oe(pad_oe[2]),
        .general_io_three_in(pad_in[3]),
        .general_io_three_out(pad_out[3]),
        .general_io_three_oe(pad_oe[3]),
        .general_io_four_in(pad_in[4]),
        .general_io_four_out(pad_out[4]),
        .general_io_four_oe(pad_oe[4]),
        .general_io_five_in(pad_in[5]),
        .general_io_five_out(pad_out[5]),
        .general_io_five_oe(pad_oe[5]),
        .power_override_level(pwr_lvl),
        .sbus_scl_drive_low(scl_low),
        .sbus_sda_drive_low(sda_low),
        .sbus_scl_in(scl_in),
        .sbus_sda_in(sda_in),
        .clock_run_support(crun),
        .outside_arbiter_select(oarb),
        .clock_stop_request_in(creq),
        .compat_mode(compat),
        .sbus_mode(sbus),
        .detect_done(done)
    );

    task automatic test_done;
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Wait n rising edges, then settle at the falling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic do_reset(input logic [5:0] pu);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        pull_up <= pu;
        cyc(2);
        chk("oe in reset", 32'h0, pad_oe);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        cyc(4);
    endtask

    // Power-on sampling of terminal two and the data terminal pull
    task automatic s_detect(input logic [5:0] pu);
        do_reset(pu);
        chk("compat", pu[2], compat);
        chk("sbus", pu[5], sbus);
        chk("done", 32'h1, done);
        @(posedge ref_clk);
        pull_up <= ~pu;
        cyc(4);
        chk("sbus held", pu[5], sbus);
        chk("compat held", pu[2], compat);
        rd(MTF_OFS_STATUS, rv);
        chk("status", {pu[5], pu[2], 2'b00} | 32'h30, rv);
        @(posedge ref_clk);
        scl_low <= 1'b1;
        sda_low <= 1'b1;
        wr(MTF_OFS_GPIO_DATA, 32'h30);
        wr(MTF_OFS_GPIO_CTRL, 32'h30);
        chk("oe45", 32'h3, pad_oe[5:4]);
        chk("out45", pu[5] ? 32'h0 : 32'h3, pad_out[5:4]);
        cyc(3);
        chk("scl in", {31'h0, ~pu[5]}, scl_in);
        chk("sda in", {31'h0, ~pu[5]}, sda_in);
        @(posedge ref_clk);
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        wr(MTF_OFS_GPIO_CTRL, 32'h0);
    endtask

    task automatic s_gpio;
        wr(MTF_OFS_GPIO_DATA, 32'h0A);
        for (int i = 0; i < 4; i++) begin
            wr(MTF_OFS_GPIO_CTRL, 32'h1 << i);
            chk("dir", 32'h1 << i, pad_oe[3:0]);
        end
        wr(MTF_OFS_GPIO_CTRL, 32'h0F);
        chk("out", 32'hA, pad_out[3:0]);
        cyc(2);
        rd(MTF_OFS_GPIO_DATA, rv);
        chk("pin levels", 32'h3A, rv);
        rd(MTF_OFS_GPIO_CTRL, rv);
        chk("gpio ctrl", 32'h0F, rv);
    endtask

    task automatic s_strap;
        @(posedge ref_clk);
        clk_strap <= 1'b1;
        arb_strap <= 1'b1;
        cyc(2);
        chk("run early", 32'h0, crun);
        cyc(1);
        chk("run on", 32'h1, crun);
        chk("arb on", 32'h1, oarb);
        chk("zero oe", 32'h0, pad_oe[0]);
        @(posedge ref_clk);
        ext_oe[0] <= 1'b1;
        ext_lvl[0] <= 1'b0;
        cyc(3);
        chk("request low", 32'h0, creq);
        rd(MTF_OFS_STATUS, rv);
        chk("status straps", 32'h3, rv[1:0]);
        @(posedge ref_clk);
        clk_strap <= 1'b0;
        arb_strap <= 1'b0;
        cyc(4);
        chk("run off", 32'h0, crun);
        chk("arb off", 32'h0, oarb);
        chk("request idle", 32'h1, creq);
        chk("zero oe back", 32'h1, pad_oe[0]);
        @(posedge ref_clk);
        ext_oe <= 6'h00;
    endtask

    task automatic s_override;
        logic e;
        wr(MTF_OFS_GPIO_CTRL, 32'h0);
        wr(MTF_OFS_GPIO_DATA, 32'h0);
        @(posedge ref_clk);
        pwr_lvl <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            e = (c == 1) || (c == 3);
            wr(MTF_OFS_GEN_CTRL, 32'hFF8FFFFF | (c << 20));
            chk("one oe", e, pad_oe[1]);
            chk("one out", e, pad_out[1]);
            rd(MTF_OFS_GEN_CTRL, rv);
            chk("gen ctrl", c << 20, rv);
        end
        wr(MTF_OFS_GEN_CTRL, 32'h0);
        chk("one released", 32'h0, pad_oe[1]);
    endtask

    task automatic s_unmapped;
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, rv);
        chk("unmapped", 32'h0, rv);
        rd(MTF_OFS_GPIO_CTRL, rv);
        chk("unmapped write", 32'h0, rv);
        rd(MTF_OFS_STATUS, rv);
        chk("status idle", 32'h30, rv);
        cyc(0);
        chk("rdata idle", 32'h0, reg_rdata);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        test_done;
    end

    initial begin
        s_detect(6'h24);
        s_detect(6'h00);
        s_gpio;
        s_strap;
        s_override;
        s_unmapped;
        test_done;
    end
endmodule // test_mtf_terminal_select
